// [design/slr_checksum.sv]
`timescale 1ns/1ps
`include "slr_defs.svh"

// ==========================================================
// Local link-parameter checksum of one link
module slr_checksum (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    // Packed configuration, byte k is register 0x400 + k
    input  wire logic [`SLR_CFG_BITS-1:0]  i_cfg,
    input  wire slr_pkg::slr_csum_mode_t   i_mode,
    // Result
    output      slr_pkg::slr_byte_t        o_sum
);

    logic [11:0] byte_sum;
    logic [11:0] field_sum;
    logic [11:0] next_sum;

    // Byte of the packed block
    function automatic logic [7:0] cfg_byte(input logic [87:0] c,
                                            input int k);
        cfg_byte = c[8*k +: 8];
    endfunction : cfg_byte

    // Plain byte sum, modulo 256 once truncated
    always_comb begin
        byte_sum = 12'h000;
        for (int k = 0; k < `SLR_CFG_BYTES; k++) begin
            byte_sum = byte_sum + {4'h0, cfg_byte(i_cfg, k)};
        end
    end

    // Each link field added on its own, so unused bits never count
    always_comb begin
        field_sum = 12'h000;
        field_sum = field_sum + {4'h0, i_cfg[7:0]};          // Device id
        field_sum = field_sum + {8'h00, i_cfg[15:12]};       // Adjust count
        field_sum = field_sum + {8'h00, i_cfg[11:8]};        // Bank id
        field_sum = field_sum + {11'h000, i_cfg[22]};        // Adjust dir
        field_sum = field_sum + {11'h000, i_cfg[21]};        // Phase adjust
        field_sum = field_sum + {7'h00, i_cfg[20:16]};       // Lane id
        field_sum = field_sum + {11'h000, i_cfg[31]};        // Scrambling
        field_sum = field_sum + {7'h00, i_cfg[28:24]};       // Lanes
        field_sum = field_sum + {4'h0, i_cfg[39:32]};        // Octets
        field_sum = field_sum + {7'h00, i_cfg[44:40]};       // Frames
        field_sum = field_sum + {4'h0, i_cfg[55:48]};        // Converters
        field_sum = field_sum + {10'h000, i_cfg[63:62]};     // Control bits
        field_sum = field_sum + {7'h00, i_cfg[60:56]};       // Resolution
        field_sum = field_sum + {9'h000, i_cfg[71:69]};      // Subclass
        field_sum = field_sum + {7'h00, i_cfg[68:64]};       // Total bits
        field_sum = field_sum + {9'h000, i_cfg[79:77]};      // Version
        field_sum = field_sum + {7'h00, i_cfg[76:72]};       // Samples
        field_sum = field_sum + {11'h000, i_cfg[87]};        // High density
        field_sum = field_sum + {7'h00, i_cfg[84:80]};       // Ctrl words
    end

    assign next_sum = (i_mode == slr_pkg::SLR_CSUM_BYTES) ? byte_sum
                                                          : field_sum;

    // Registered so the compare value never glitches on a read
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_sum <= 8'h00;
        end else begin
            o_sum <= next_sum[7:0];
        end
    end

endmodule : slr_checksum

// [design/slr_defs.svh]
`ifndef SLR_DEFS_SVH
`define SLR_DEFS_SVH

// ==========================================================
// Register offsets
`define SLR_OFF_TERM_CAL_B     12'h2AE
`define SLR_OFF_TERM_SETUP_A   12'h2B1
`define SLR_OFF_TERM_SETUP_B   12'h2B2
`define SLR_OFF_RX_GEN_CTRL    12'h300
`define SLR_OFF_PAGED_LO       12'h401
`define SLR_OFF_PAGED_HI       12'h47E
`define SLR_OFF_CMP_0          12'h40E
`define SLR_OFF_CMP_1          12'h416
`define SLR_OFF_CMP_2          12'h41E
`define SLR_OFF_CMP_3          12'h42E
`define SLR_OFF_CMP_4          12'h43E
`define SLR_OFF_CMP_5          12'h446

// ==========================================================
// Field positions in the general receiver control register and the calibration trigger register
`define SLR_BIT_CSUM_MODE      6
`define SLR_BIT_LINK_MODE      3
`define SLR_BIT_LINK_PAGE      2
`define SLR_BIT_LINK_EN_HI     1
`define SLR_BIT_LINK_EN_LO     0
`define SLR_BIT_TERM_CAL       0

// ==========================================================
// Reset values and writable masks
`define SLR_RST_TERM_CAL_B     8'h00
`define SLR_RST_TERM_SETUP_A   8'hC3
`define SLR_RST_TERM_SETUP_B   8'h93
`define SLR_RST_RX_GEN_CTRL    8'h00
`define SLR_MASK_TERM_CAL_B    8'h01
`define SLR_MASK_RX_GEN_CTRL   8'h4F

// ==========================================================
// Packed configuration block: bytes 0x400 to 0x40A
`define SLR_CFG_BYTES          11
`define SLR_CFG_BITS           88
`define SLR_NUM_LINKS          2
`define SLR_NUM_CMP            6

`endif

// [design/slr_pkg.sv]
// ==========================================================
// Shared types of the receiver general control bank
package slr_pkg;

    typedef logic [7:0]  slr_byte_t;
    typedef logic [11:0] slr_addr_t;

    // Link arrangement selected by the link mode bit
    typedef enum logic [0:0] {
        SLR_SINGLE_LINK = 1'b0,
        SLR_DUAL_LINK   = 1'b1
    } slr_link_mode_t;

    // Checksum method selected by the checksum mode bit
    typedef enum logic [0:0] {
        SLR_CSUM_FIELDS = 1'b0,
        SLR_CSUM_BYTES  = 1'b1
    } slr_csum_mode_t;

endpackage : slr_pkg

// [design/slr_rx_general_ctrl.sv]
// Operation
// - Rising edge of calibration bit 0 calibrates lane PHYs two to five.
// - Checksum mode 0 sums the individual link configuration fields.
// - Checksum mode 1 sums bytes 0x400 to 0x40A modulo 256.
// - Local checksum readable in the six per-lane compare registers.
// - Link mode bit 3 selects single link or dual link, reset 0.
// - Page bit 2 picks the link 0 or link 1 checksum at the compare offsets in 0x401 to 0x47E.
// - Bits 1:0 enable link 0 and link 1 logic; reset both off.
`timescale 1ns/1ps
`include "slr_defs.svh"

module slr_rx_general_ctrl (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    // Register port from the serial control port
    input  wire slr_pkg::slr_addr_t        i_reg_addr,
    input  wire logic                      i_reg_wen,
    input  wire logic                      i_reg_ren,
    input  wire slr_pkg::slr_byte_t        i_reg_wdata,
    output      slr_pkg::slr_byte_t        o_reg_rdata,
    output      logic                      o_reg_rvalid,
    output      logic                      o_reg_hit,
    // Packed configuration blocks of both links
    input  wire logic [`SLR_CFG_BITS-1:0]  i_link0_cfg,
    input  wire logic [`SLR_CFG_BITS-1:0]  i_link1_cfg,
    // Termination control
    output      logic                      o_term_cal_start_b,
    output      slr_pkg::slr_byte_t        o_term_setup_a,
    output      slr_pkg::slr_byte_t        o_term_setup_b,
    // Receiver control
    output      slr_pkg::slr_link_mode_t   o_link_mode,
    output      logic                      o_link_page,
    output      logic [1:0]                o_link_en,
    output      slr_pkg::slr_csum_mode_t   o_csum_mode,
    output      slr_pkg::slr_byte_t        o_link0_checksum,
    output      slr_pkg::slr_byte_t        o_link1_checksum
);

    // ==========================================================
    // Storage
    slr_pkg::slr_byte_t term_cal_b;
    slr_pkg::slr_byte_t term_setup_a;
    slr_pkg::slr_byte_t term_setup_b;
    slr_pkg::slr_byte_t rx_gen_ctrl;
    slr_pkg::slr_byte_t csum [`SLR_NUM_LINKS];
    slr_pkg::slr_byte_t paged_csum;
    slr_pkg::slr_byte_t next_rdata;
    logic               next_hit;
    logic               term_cal_prev;

    // Write strobes, one for each stored register
    logic               wr_term_cal_b;
    logic               wr_term_setup_a;
    logic               wr_term_setup_b;
    logic               wr_rx_gen_ctrl;

    // One flag for each per-lane compare offset
    logic [`SLR_NUM_CMP-1:0] cmp_match;

    // Exact offset match, used by write and read decode
    function automatic logic at(input slr_pkg::slr_addr_t a,
                                input slr_pkg::slr_addr_t off);
        at = (a == off);
    endfunction : at

    // Offset of the n-th per-lane compare register
    function automatic slr_pkg::slr_addr_t cmp_off(input int n);
        case (n)
            0:       cmp_off = `SLR_OFF_CMP_0;
            1:       cmp_off = `SLR_OFF_CMP_1;
            2:       cmp_off = `SLR_OFF_CMP_2;
            3:       cmp_off = `SLR_OFF_CMP_3;
            4:       cmp_off = `SLR_OFF_CMP_4;
            default: cmp_off = `SLR_OFF_CMP_5;
        endcase
    endfunction : cmp_off

    // ==========================================================
    // Write decode; strobes to unmapped or read-only offsets,
    // the compare registers among them, change nothing
    assign wr_term_cal_b   = i_reg_wen &&
                             at(i_reg_addr, `SLR_OFF_TERM_CAL_B);
    assign wr_term_setup_a = i_reg_wen &&
                             at(i_reg_addr, `SLR_OFF_TERM_SETUP_A);
    assign wr_term_setup_b = i_reg_wen &&
                             at(i_reg_addr, `SLR_OFF_TERM_SETUP_B);
    assign wr_rx_gen_ctrl  = i_reg_wen &&
                             at(i_reg_addr, `SLR_OFF_RX_GEN_CTRL);

    // Compare offsets matched by one comparator each
    for (genvar n = 0; n < `SLR_NUM_CMP; n++) begin : g_cmp
        assign cmp_match[n] = at(i_reg_addr, cmp_off(n));
    end

    // ==========================================================
    // Calibration trigger register
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            term_cal_b <= `SLR_RST_TERM_CAL_B;
        end else if (wr_term_cal_b) begin
            term_cal_b <= i_reg_wdata & `SLR_MASK_TERM_CAL_B;
        end
    end

    // Only a 0 to 1 change starts calibration; rewriting 1 does nothing
    // Software clears the bit first to run calibration again
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            term_cal_prev      <= 1'b0;
            o_term_cal_start_b <= 1'b0;
        end else begin
            term_cal_prev      <= term_cal_b[`SLR_BIT_TERM_CAL];
            o_term_cal_start_b <= term_cal_b[`SLR_BIT_TERM_CAL] &&
                                  !term_cal_prev;
        end
    end

    // ==========================================================
    // Termination setup registers, full bytes, forwarded to the PHYs
    // No bit is reserved here, so the whole byte is kept
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            term_setup_a <= `SLR_RST_TERM_SETUP_A;
        end else if (wr_term_setup_a) begin
            term_setup_a <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            term_setup_b <= `SLR_RST_TERM_SETUP_B;
        end else if (wr_term_setup_b) begin
            term_setup_b <= i_reg_wdata;
        end
    end

    assign o_term_setup_a = term_setup_a;
    assign o_term_setup_b = term_setup_b;

    // ==========================================================
    // General receiver control; enables are not interlocked here,
    // the bring-up order is left to software
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            rx_gen_ctrl <= `SLR_RST_RX_GEN_CTRL;
        end else if (wr_rx_gen_ctrl) begin
            rx_gen_ctrl <= i_reg_wdata & `SLR_MASK_RX_GEN_CTRL;
        end
    end

    assign o_link_mode = slr_pkg::slr_link_mode_t'(
                             rx_gen_ctrl[`SLR_BIT_LINK_MODE]);
    assign o_link_page = rx_gen_ctrl[`SLR_BIT_LINK_PAGE];
    assign o_link_en   = rx_gen_ctrl[`SLR_BIT_LINK_EN_HI:
                                     `SLR_BIT_LINK_EN_LO];
    assign o_csum_mode = slr_pkg::slr_csum_mode_t'(
                             rx_gen_ctrl[`SLR_BIT_CSUM_MODE]);

    // ==========================================================
    // Local checksum of each link; both run whether enabled or
    // not, so the compare value is ready before a link comes up
    for (genvar g = 0; g < `SLR_NUM_LINKS; g++) begin : g_csum
        slr_checksum slr_checksum_inst (
            .i_core_clk (i_core_clk),
            .i_rstn     (i_rstn),
            .i_cfg      ((g == 0) ? i_link0_cfg : i_link1_cfg),
            .i_mode     (o_csum_mode),
            .o_sum      (csum[g])
        );
    end

    assign o_link0_checksum = csum[0];
    assign o_link1_checksum = csum[1];

    // Paged view; the page bit alone picks the link, the link
    // mode does not gate it, so software can read either side
    assign paged_csum = csum[o_link_page];

    // ==========================================================
    // Read decode; unmapped offsets read zero and drop the hit flag
    // The hit flag tells a real zero from an unmapped offset
    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b1;
        if (at(i_reg_addr, `SLR_OFF_TERM_CAL_B)) begin
            next_rdata = term_cal_b;
        end else if (at(i_reg_addr, `SLR_OFF_TERM_SETUP_A)) begin
            next_rdata = term_setup_a;
        end else if (at(i_reg_addr, `SLR_OFF_TERM_SETUP_B)) begin
            next_rdata = term_setup_b;
        end else if (at(i_reg_addr, `SLR_OFF_RX_GEN_CTRL)) begin
            next_rdata = rx_gen_ctrl;
        end else if (|cmp_match) begin
            // Compare offsets: the page bit picks whose checksum shows
            next_rdata = paged_csum;
        end else begin
            next_hit = 1'b0;
        end
    end

    // Read data one cycle after the strobe, held until the next read
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
            o_reg_hit   <= 1'b0;
        end else if (i_reg_ren) begin
            o_reg_rdata <= next_rdata;
            o_reg_hit   <= next_hit;
        end
    end

    // Valid marks the one cycle in which a fresh answer appears;
    // a write in the same cycle as a read is not seen by that read
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_ren;
        end
    end

endmodule : slr_rx_general_ctrl

// [verif/slr_rx_general_ctrl_chk.sv]
`timescale 1ns/1ps
`include "slr_defs.svh"

// ==========================================================
// Port checker of the receiver general control bank
module slr_rx_general_ctrl_chk (
    // Clock and reset
    input wire logic                     i_core_clk,
    input wire logic                     i_rstn,
    // Register port
    input wire slr_pkg::slr_addr_t       i_reg_addr,
    input wire logic                     i_reg_wen,
    input wire logic                     i_reg_ren,
    input wire slr_pkg::slr_byte_t       i_reg_wdata,
    input wire slr_pkg::slr_byte_t       o_reg_rdata,
    input wire logic                     o_reg_rvalid,
    // Configuration and controls
    input wire logic [`SLR_CFG_BITS-1:0] i_link0_cfg,
    input wire logic                     o_term_cal_start_b,
    input wire slr_pkg::slr_byte_t       o_term_setup_a,
    input wire slr_pkg::slr_byte_t       o_term_setup_b,
    input wire slr_pkg::slr_link_mode_t  o_link_mode,
    input wire logic                     o_link_page,
    input wire logic [1:0]               o_link_en,
    input wire slr_pkg::slr_csum_mode_t  o_csum_mode,
    input wire slr_pkg::slr_byte_t       o_link0_checksum
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    // Byte sum kept apart from the design so a shared slip cannot hide
    function automatic logic [7:0] bsum(input logic [87:0] c);
        bsum = 8'h00;
        for (int k = 0; k < 11; k++) bsum += c[8*k +: 8];
    endfunction : bsum

    logic ctl_wr;
    assign ctl_wr = i_reg_wen && (i_reg_addr == 12'h300);

    a_cal_one_pulse: assert property (
        o_term_cal_start_b |=> !o_term_cal_start_b)
        else $error("calibration pulse longer than one cycle");
    a_cal_after_write: assert property (
        $rose(o_term_cal_start_b) |-> $past(i_reg_wen, 2)
        && $past(i_reg_addr, 2) == 12'h2AE && $past(i_reg_wdata[0], 2))
        else $error("calibration pulse without a write of one");
    a_setup_a_write: assert property (
        i_reg_wen && i_reg_addr == 12'h2B1
        |=> o_term_setup_a == $past(i_reg_wdata))
        else $error("setup A did not take written byte");
    a_setup_b_write: assert property (
        i_reg_wen && i_reg_addr == 12'h2B2
        |=> o_term_setup_b == $past(i_reg_wdata))
        else $error("setup B did not take written byte");
    a_link_mode_write: assert property (
        ctl_wr |=> o_link_mode == $past(i_reg_wdata[3]))
        else $error("link mode not from bit 3");
    a_link_page_write: assert property (
        ctl_wr |=> o_link_page == $past(i_reg_wdata[2]))
        else $error("link page not from bit 2");
    a_link_en_write: assert property (
        ctl_wr |=> o_link_en == $past(i_reg_wdata[1:0]))
        else $error("link enables not from bits 1:0");
    a_csum_mode_write: assert property (
        ctl_wr |=> o_csum_mode == $past(i_reg_wdata[6]))
        else $error("checksum mode not from bit 6");
    a_ctrl_hold: assert property (
        !ctl_wr |=> $stable({o_link_mode, o_link_page,
                             o_link_en, o_csum_mode}))
        else $error("control bits changed without a write");
    a_csum_bytes: assert property (
        o_csum_mode == slr_pkg::SLR_CSUM_BYTES
        |=> o_link0_checksum == bsum($past(i_link0_cfg)))
        else $error("byte checksum of link 0 wrong");
    a_read_rsvd: assert property (
        i_reg_ren && i_reg_addr == 12'h300
        |=> o_reg_rvalid && o_reg_rdata[7] == 1'b0 && o_reg_rdata[5:4] == 2'h0)
        else $error("reserved control bits read nonzero");
endmodule : slr_rx_general_ctrl_chk

bind slr_rx_general_ctrl slr_rx_general_ctrl_chk slr_rx_general_ctrl_chk_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
    .i_reg_wen(i_reg_wen), .i_reg_ren(i_reg_ren), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_link0_cfg(i_link0_cfg), .o_term_cal_start_b(o_term_cal_start_b),
    .o_term_setup_a(o_term_setup_a), .o_term_setup_b(o_term_setup_b),
    .o_link_mode(o_link_mode), .o_link_page(o_link_page),
    .o_link_en(o_link_en), .o_csum_mode(o_csum_mode),
    .o_link0_checksum(o_link0_checksum));

// [verif/test_slr_rx_general_ctrl.sv]
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench of the receiver general control bank
module test_slr_rx_general_ctrl;
    logic               i_core_clk = 1'b0;
    logic               i_rstn = 1'b0;
    slr_pkg::slr_addr_t i_reg_addr = 12'h000;
    logic               i_reg_wen = 1'b0;
    logic               i_reg_ren = 1'b0;
    slr_pkg::slr_byte_t i_reg_wdata = 8'h00;
    // Link 0 mixes sub-fields, link 1 hits only top bits of each byte
    logic [87:0] i_link0_cfg = {48'h0, 8'h05, 8'h00, 8'hFF, 8'h34, 8'h12};
    logic [87:0] i_link1_cfg = {11{8'h80}};
    slr_pkg::slr_byte_t o_reg_rdata, o_term_setup_a, o_term_setup_b;
    slr_pkg::slr_byte_t o_link0_checksum, o_link1_checksum;
    logic o_reg_rvalid, o_reg_hit, o_term_cal_start_b, o_link_page;
    logic [1:0] o_link_en;
    slr_pkg::slr_link_mode_t o_link_mode;
    slr_pkg::slr_csum_mode_t o_csum_mode;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    slr_rx_general_ctrl slr_rx_general_ctrl_inst (
        .i_core_clk         (i_core_clk),
        .i_rstn             (i_rstn),
        .i_reg_addr         (i_reg_addr),
        .i_reg_wen          (i_reg_wen),
        .i_reg_ren          (i_reg_ren),
        .i_reg_wdata        (i_reg_wdata),
        .o_reg_rdata        (o_reg_rdata),
        .o_reg_rvalid       (o_reg_rvalid),
        .o_reg_hit          (o_reg_hit),
        .i_link0_cfg        (i_link0_cfg),
        .i_link1_cfg        (i_link1_cfg),
        .o_term_cal_start_b (o_term_cal_start_b),
        .o_term_setup_a     (o_term_setup_a),
        .o_term_setup_b     (o_term_setup_b),
        .o_link_mode        (o_link_mode),
        .o_link_page        (o_link_page),
        .o_link_en          (o_link_en),
        .o_csum_mode        (o_csum_mode),
        .o_link0_checksum   (o_link0_checksum),
        .o_link1_checksum   (o_link1_checksum)
    );

    // 25 MHz clock and a ceiling far above the fewer than one hundred cycles used
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    // Strobe is held for exactly the one taking edge
    task wr(input slr_pkg::slr_addr_t a, input slr_pkg::slr_byte_t d);
        @(posedge i_core_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wen   <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wen <= 1'b0;
        #1;
    endtask : wr

    task rd(input slr_pkg::slr_addr_t a, input logic [7:0] exp, input logic h);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_ren  <= 1'b1;
        @(posedge i_core_clk);
        i_reg_ren <= 1'b0;
        #1;
        cmp("rvalid", 8'h01, {7'h0, o_reg_rvalid});
        cmp("rdata", exp, o_reg_rdata);
        cmp("hit", {7'h0, h}, {7'h0, o_reg_hit});
    endtask : rd

    task pulses(input int exp);
        int n;
        n = 0;
        repeat (4) begin
            @(posedge i_core_clk);
            #1;
            if (o_term_cal_start_b !== 1'b0) n++; // Unknown counts too
        end
        cmp("cal_pulses", exp[7:0], n[7:0]);
    endtask : pulses

    task t_reset();
        cmp("setup_a", 8'hC3, o_term_setup_a);
        cmp("setup_b", 8'h93, o_term_setup_b);
        cmp("link_en", 8'h00, {6'h0, o_link_en});
        cmp("link_mode", 8'h00, {7'h0, o_link_mode});
        cmp("csum_mode", 8'h00, {7'h0, o_csum_mode});
        rd(12'h300, 8'h00, 1'b1);
        rd(12'h2AE, 8'h00, 1'b1);
        rd(12'h2B1, 8'hC3, 1'b1);
        rd(12'h2B2, 8'h93, 1'b1);
    endtask : t_reset

    task t_setup();
        wr(12'h2B1, 8'hB7);
        wr(12'h2B2, 8'h87);
        cmp("setup_a", 8'hB7, o_term_setup_a);
        cmp("setup_b", 8'h87, o_term_setup_b);
        rd(12'h2B1, 8'hB7, 1'b1);
    endtask : t_setup

    task t_ctrl();
        // Reserved bits 7 and 5:4 set on every write must stay dropped
        for (int v = 0; v < 4; v++) begin
            wr(12'h300, 8'hB0 | v[7:0]);
            cmp("link_en", v[7:0], {6'h0, o_link_en});
            rd(12'h300, v[7:0], 1'b1);
        end
        wr(12'h300, 8'hFF);
        cmp("link_mode", 8'h01, {7'h0, o_link_mode});
        cmp("link_page", 8'h01, {7'h0, o_link_page});
        cmp("csum_mode", 8'h01, {7'h0, o_csum_mode});
        rd(12'h300, 8'h4F, 1'b1);
    endtask : t_ctrl

    task t_cal();
        wr(12'h2AE, 8'hFF);
        pulses(1);
        rd(12'h2AE, 8'h01, 1'b1);
        wr(12'h2AE, 8'h01);
        pulses(0);
        wr(12'h2AE, 8'h00);
        pulses(0);
        wr(12'h2AE, 8'h01);
        pulses(1);
    endtask : t_cal

    task t_csum();
        wr(12'h300, 8'h00);
        repeat (2) @(posedge i_core_clk);
        #1;
        cmp("sum0_fields", 8'h3F, o_link0_checksum);
        cmp("sum1_fields", 8'h94, o_link1_checksum);
        rd(12'h40E, 8'h3F, 1'b1);
        wr(12'h300, 8'h04);
        rd(12'h446, 8'h94, 1'b1);
        wr(12'h300, 8'h40);
        repeat (2) @(posedge i_core_clk);
        #1;
        cmp("sum0_bytes", 8'h4A, o_link0_checksum);
        cmp("sum1_bytes", 8'h80, o_link1_checksum);
        wr(12'h40E, 8'h00);
        rd(12'h41E, 8'h4A, 1'b1);
        wr(12'h300, 8'h44);
        rd(12'h42E, 8'h80, 1'b1);
        rd(12'h43E, 8'h80, 1'b1);
        rd(12'h123, 8'h00, 1'b0);
    endtask : t_csum

    // Main sequence: three reset cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        #1;
        t_reset();
        t_setup();
        t_ctrl();
        t_cal();
        t_csum();
        give_verdict();
    end
endmodule : test_slr_rx_general_ctrl
